// ### rtl/l2port_pkg.sv
/*
 Constants, field layouts and state types of the secondary-cache port.
 Assumes a single 250 MHz processor-bus clock for every user.
*/
package l2port_pkg;
	// --------------------------------------------------------------------
	// register map
	// --------------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] ADDR_CONFIG = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [1:0] SEL_NONE = 2'h0;
	localparam logic [1:0] SEL_CFG = 2'h1;
	localparam logic [1:0] SEL_STAT = 2'h2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	// config fields; polarity bit set means active high
	localparam int CFG_W = 9;
	localparam int CFG_MODE = 0;
	localparam int CFG_BURST = 2;
	localparam int CFG_HIT_POL = 3;
	localparam int CFG_DIN_POL = 4;
	localparam int CFG_DOUT_POL = 5;
	localparam int CFG_TV_POL = 6;
	localparam int CFG_LOCK = 8;
	localparam logic [8:0] CFG_RESET = 9'h078;
	localparam logic [1:0] MODE_BAD = 2'h3;
	localparam int ST_W = 10;
	// --------------------------------------------------------------------
	// pin functions and sequencing
	// --------------------------------------------------------------------
	typedef enum logic [1:0] {MODE_INTERNAL, MODE_EXTERNAL, MODE_MULTI} pin_mode_t;
	typedef enum logic [1:0] {C_IDLE, C_LOOKUP, C_DATA, C_TAG} cache_state_t;
	localparam logic [1:0] LOOKUP_LAST = 2'h2;
	localparam logic [1:0] BURST_LAST = 2'h3;
	localparam logic [1:0] OWN_EXT = 2'h0;
	localparam logic [1:0] OWN_CPU1 = 2'h1;
	localparam logic [1:0] OWN_CPU2 = 2'h2;
	localparam logic [1:0] OWN_CPU3 = 2'h3;
	// synchroniser lanes
	localparam int SYNC_W = 8;
	localparam int SY_STROBE = 0;
	localparam int SY_BA0 = 1;
	localparam int SY_DIRTY = 2;
	localparam int SY_HIT = 3;
	localparam int SY_TV = 4;
	localparam int SY_ADDR_ACK = 5;
	localparam int SY_TA = 6;
	localparam int SY_TBST = 7;
endpackage

// ### rtl/l2_cache_and_multiprocessor_port.sv
/*
 Secondary-cache port of a host bridge: internal cache sequencer, pin reuse
 for an external cache controller or extra processors, and a bus arbiter.
 Assumes one clock, an AXI4-Lite master for configuration, and that the
 bridge core starts cache accesses on the same clock.
*/
`timescale 1ns/1ps
// What this block does
// - in burst SRAM mode pulse the address strobe when the address is valid
// - in async SRAM mode drive the two burst counter bits from the counter
// - in burst SRAM mode assert advance on each following beat
// - in async SRAM mode pulse the latch enable for the external address latch
// - select the data SRAMs for every cache read or write hit
// - read the line-modified input with programmable polarity
// - drive mark-modified with programmable polarity when a written line is dirty
// - enable data SRAM output only when they drive the data bus
// - drive three identical data write enables during a data write
// - read the hit input with programmable polarity as tag compare result
// - enable tag SRAM output while the stored tag is looked up
// - drive tag valid with programmable polarity to mark the line valid
// - pulse tag write to update tag, valid and dirty together
// - external controller mode reuses exactly three cache pins
// - external controller requests the bus and gets an address grant
// - grant the data bus to the external controller when it owns it
// - multiprocessor mode reuses nine cache pins as requests and grants
// - each extra processor has its own address grant
// - each extra processor has its own data grant
// - all other bus signals are shared by every processor
module l2_cache_and_multiprocessor_port (
	// clock, reset, enable
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [7:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// cache access from the bridge core
	input wire logic cache_start_i,
	input wire logic cache_write_i,
	input wire logic cache_burst_i,
	input wire logic [1:0] cache_word_i,
	output logic cache_busy_o,
	output logic cache_done_o,
	output logic cache_hit_o,
	output logic cache_dirty_o,
	// shared processor bus inputs
	input wire logic addr_ack_i,
	input wire logic transfer_ack_i,
	input wire logic xfer_burst_i,
	// reused cache pins
	input wire logic strobe_pin_i,
	output logic strobe_pin_o,
	output logic strobe_pin_oe_n_o,
	input wire logic ba0_pin_i,
	output logic ba0_pin_o,
	output logic ba0_pin_oe_n_o,
	input wire logic tv_pin_i,
	output logic tv_pin_o,
	output logic tv_pin_oe_n_o,
	input wire logic dirty_pin_i,
	input wire logic hit_i,
	output logic adv_pin_o,
	output logic dcs_pin_o,
	output logic dirty_out_pin_o,
	output logic doe_pin_o,
	output logic [2:0] dwe_pin_o,
	output logic toe_pin_o,
	output logic twe_pin_o
);
	// --------------------------------------------------------------------
	// helpers
	// --------------------------------------------------------------------
	function automatic logic [1:0] reg_sel(input logic [7:0] a);
		if (a == l2port_pkg::ADDR_CONFIG)
			return l2port_pkg::SEL_CFG;
		if (a == l2port_pkg::ADDR_STATUS)
			return l2port_pkg::SEL_STAT;
		return l2port_pkg::SEL_NONE;
	endfunction

	// same xnor serves input decode and output drive
	function automatic logic pol_level(input logic x, input logic pol);
		return x ~^ pol;
	endfunction

	logic awready, wready, bvalid, arready, rvalid, do_write;
	logic [1:0] bresp, rresp;
	logic [7:0] aw_addr;
	logic [31:0] w_data, rdata;
	logic [3:0] w_strb;
	logic [8:0] cfg;
	logic [9:0] status;
	logic [7:0] pin_raw, sync_a, sync_b;
	l2port_pkg::pin_mode_t mode;
	l2port_pkg::cache_state_t c_state;
	logic in_int, in_ext, in_mp, cfg_burst, line_hit, line_dirty, line_valid;
	logic [1:0] lk_cnt, beats, bcnt;
	logic w_write, w_burst, done, last_hit, last_dirty, last_valid, lookup_first, beat_first;
	logic [3:0] req;
	logic [1:0] pick, cand, last, aowner, downer, dbeats;
	logic pick_ok, abusy, dbusy;
	logic next_strobe, next_strobe_oe_n, next_ba0, next_ba0_oe_n, next_tv, next_tv_oe_n;
	logic next_adv, next_dcs, next_dirty_out, next_doe, next_toe, next_twe;
	logic [2:0] next_dwe;

	// --------------------------------------------------------------------
	// register bus
	// --------------------------------------------------------------------
	// write path: address and data taken in either order, response after both
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= l2port_pkg::RESP_OKAY;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else if (ce_i) begin
			if (s_axi_awvalid_i && awready) begin
				aw_addr <= s_axi_awaddr_i;
				awready <= 1'b0;
			end
			if (s_axi_wvalid_i && wready) begin
				w_data <= s_axi_wdata_i;
				w_strb <= s_axi_wstrb_i;
				wready <= 1'b0;
			end
			if (do_write) begin
				bvalid <= 1'b1;
				bresp <= (reg_sel(aw_addr) == l2port_pkg::SEL_NONE) ?
					l2port_pkg::RESP_DECERR : l2port_pkg::RESP_OKAY;
			end
			if (bvalid && s_axi_bready_i) begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end
	assign do_write = !awready && !wready && !bvalid;

	// config: frozen once locked, and only changed with the port quiet
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			cfg <= l2port_pkg::CFG_RESET;
		end else if (ce_i && do_write && reg_sel(aw_addr) == l2port_pkg::SEL_CFG &&
			!cfg[l2port_pkg::CFG_LOCK] && c_state == l2port_pkg::C_IDLE && !abusy && !dbusy) begin
			// a reserved mode code leaves the whole low byte alone
			if (w_strb[0] && w_data[1:0] != l2port_pkg::MODE_BAD)
				cfg[6:0] <= w_data[6:0];
			if (w_strb[1])
				cfg[l2port_pkg::CFG_LOCK] <= w_data[l2port_pkg::CFG_LOCK];
		end
	end

	assign status = {downer, dbusy, aowner, abusy, last_valid, last_dirty, last_hit,
		c_state != l2port_pkg::C_IDLE};

	// read path: one outstanding read, unmapped answers decode error
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= l2port_pkg::RESP_OKAY;
		end else if (ce_i) begin
			if (s_axi_arvalid_i && arready) begin
				arready <= 1'b0;
				rvalid <= 1'b1;
				rresp <= l2port_pkg::RESP_OKAY;
				case (reg_sel(s_axi_araddr_i))
					l2port_pkg::SEL_CFG: rdata <= {23'h000000, cfg};
					l2port_pkg::SEL_STAT: rdata <= {22'h000000, status};
					default: begin
						rdata <= 32'h0000_0000;
						rresp <= l2port_pkg::RESP_DECERR;
					end
				endcase
			end else if (rvalid && s_axi_rready_i) begin
				rvalid <= 1'b0;
				arready <= 1'b1;
			end
		end
	end

	// --------------------------------------------------------------------
	// pin synchronisers
	// --------------------------------------------------------------------
	assign pin_raw = {xfer_burst_i, transfer_ack_i, addr_ack_i, tv_pin_i, hit_i, dirty_pin_i,
		ba0_pin_i, strobe_pin_i};
	generate
		for (genvar g = 0; g < l2port_pkg::SYNC_W; g++) begin : g_sync
			always_ff @(posedge clock_i) begin
				if (rst_i) begin
					sync_a[g] <= 1'b0;
					sync_b[g] <= 1'b0;
				end else if (ce_i) begin
					sync_a[g] <= pin_raw[g];
					sync_b[g] <= sync_a[g];
				end
			end
		end
	endgenerate

	// mode decode and polarity-corrected cache inputs
	assign mode = l2port_pkg::pin_mode_t'(cfg[l2port_pkg::CFG_MODE +: 2]);
	assign in_int = mode == l2port_pkg::MODE_INTERNAL;
	assign in_ext = mode == l2port_pkg::MODE_EXTERNAL;
	assign in_mp = mode == l2port_pkg::MODE_MULTI;
	assign cfg_burst = cfg[l2port_pkg::CFG_BURST];
	assign line_hit = pol_level(sync_b[l2port_pkg::SY_HIT], cfg[l2port_pkg::CFG_HIT_POL]);
	assign line_dirty = pol_level(sync_b[l2port_pkg::SY_DIRTY], cfg[l2port_pkg::CFG_DIN_POL]);
	assign line_valid = pol_level(sync_b[l2port_pkg::SY_TV], cfg[l2port_pkg::CFG_TV_POL]);

	// --------------------------------------------------------------------
	// internal cache sequencer
	// --------------------------------------------------------------------
	// lookup waits out the two-stage pin sync before the tag answer is used
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			c_state <= l2port_pkg::C_IDLE;
			lk_cnt <= 2'h0;
			beats <= 2'h0;
			bcnt <= 2'h0;
			w_write <= 1'b0;
			w_burst <= 1'b0;
			done <= 1'b0;
			last_hit <= 1'b0;
			last_dirty <= 1'b0;
			last_valid <= 1'b0;
		end else if (ce_i) begin
			done <= 1'b0;
			case (c_state)
				l2port_pkg::C_IDLE: begin
					if (in_int && cache_start_i) begin
						c_state <= l2port_pkg::C_LOOKUP;
						lk_cnt <= 2'h0;
						w_write <= cache_write_i;
						w_burst <= cache_burst_i;
						bcnt <= cache_word_i;
						beats <= cache_burst_i ? l2port_pkg::BURST_LAST : 2'h0;
					end
				end
				l2port_pkg::C_LOOKUP: begin
					if (lk_cnt == l2port_pkg::LOOKUP_LAST) begin
						last_hit <= line_hit;
						last_dirty <= line_dirty;
						last_valid <= line_valid;
						// read miss allocates a clean line; write miss does not allocate
						if (line_hit) begin
							c_state <= l2port_pkg::C_DATA;
						end else if (!w_write) begin
							c_state <= l2port_pkg::C_TAG;
						end else begin
							c_state <= l2port_pkg::C_IDLE;
							done <= 1'b1;
						end
					end else begin
						lk_cnt <= lk_cnt + 2'h1;
					end
				end
				l2port_pkg::C_DATA: begin
					bcnt <= bcnt + 2'h1;
					if (beats == 2'h0) begin
						if (w_write) begin
							c_state <= l2port_pkg::C_TAG;
						end else begin
							c_state <= l2port_pkg::C_IDLE;
							done <= 1'b1;
						end
					end else begin
						beats <= beats - 2'h1;
					end
				end
				l2port_pkg::C_TAG: begin
					c_state <= l2port_pkg::C_IDLE;
					done <= 1'b1;
				end
				default: c_state <= l2port_pkg::C_IDLE;
			endcase
		end
	end
	assign lookup_first = c_state == l2port_pkg::C_LOOKUP && lk_cnt == 2'h0;
	assign beat_first = w_burst ? (beats == l2port_pkg::BURST_LAST) : 1'b1;

	// --------------------------------------------------------------------
	// bus arbiter for external controller and extra processors
	// --------------------------------------------------------------------
	// lane 0 is the external controller, lanes 1..3 the extra processors
	assign req = in_ext ? {3'h0, sync_b[l2port_pkg::SY_STROBE]} :
		in_mp ? {sync_b[l2port_pkg::SY_BA0], sync_b[l2port_pkg::SY_TV],
		sync_b[l2port_pkg::SY_DIRTY], 1'b0} : 4'h0;

	// round robin starting after the last owner
	always_comb begin
		pick = last;
		pick_ok = 1'b0;
		cand = last;
		for (int i = 1; i <= 4; i++) begin
			cand = last + i[1:0];
			if (!pick_ok && req[cand]) begin
				pick = cand;
				pick_ok = 1'b1;
			end
		end
	end

	// one owner per bus keeps the shared signals single-driven; no pipelining
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			abusy <= 1'b0;
			dbusy <= 1'b0;
			aowner <= 2'h0;
			downer <= 2'h0;
			last <= 2'h0;
			dbeats <= 2'h0;
		end else if (ce_i) begin
			if (!abusy && !dbusy && pick_ok) begin
				abusy <= 1'b1;
				aowner <= pick;
				last <= pick;
			end else if (abusy && sync_b[l2port_pkg::SY_ADDR_ACK]) begin
				abusy <= 1'b0;
				dbusy <= 1'b1;
				downer <= aowner;
				dbeats <= sync_b[l2port_pkg::SY_TBST] ? l2port_pkg::BURST_LAST : 2'h0;
			end
			if (dbusy && sync_b[l2port_pkg::SY_TA]) begin
				if (dbeats == 2'h0)
					dbusy <= 1'b0;
				else
					dbeats <= dbeats - 2'h1;
			end
		end
	end

	// --------------------------------------------------------------------
	// pin function select
	// --------------------------------------------------------------------
	always_comb begin
		next_strobe = 1'b0;
		next_strobe_oe_n = 1'b1;
		next_ba0 = 1'b0;
		next_ba0_oe_n = 1'b1;
		next_tv = 1'b0;
		next_tv_oe_n = 1'b1;
		next_adv = 1'b0;
		next_dcs = 1'b0;
		next_dirty_out = 1'b0;
		next_doe = 1'b0;
		next_dwe = 3'h0;
		next_toe = 1'b0;
		next_twe = 1'b0;
		case (mode)
			l2port_pkg::MODE_INTERNAL: begin
				next_strobe_oe_n = 1'b0;
				next_ba0_oe_n = 1'b0;
				next_strobe = lookup_first;
				next_ba0 = cfg_burst ? 1'b0 : bcnt[0];
				next_adv = cfg_burst ? (c_state == l2port_pkg::C_DATA && !beat_first) :
					bcnt[1];
				next_dcs = c_state == l2port_pkg::C_DATA;
				next_doe = c_state == l2port_pkg::C_DATA && !w_write;
				next_dwe = {3{c_state == l2port_pkg::C_DATA && w_write}};
				next_toe = c_state == l2port_pkg::C_LOOKUP;
				next_twe = c_state == l2port_pkg::C_TAG;
				next_dirty_out = pol_level(c_state == l2port_pkg::C_TAG && w_write,
					cfg[l2port_pkg::CFG_DOUT_POL]);
				next_tv_oe_n = c_state != l2port_pkg::C_TAG;
				next_tv = pol_level(1'b1, cfg[l2port_pkg::CFG_TV_POL]);
			end
			l2port_pkg::MODE_EXTERNAL: begin
				// strobe becomes an input; advance and data oe become grants
				next_adv = abusy && aowner == l2port_pkg::OWN_EXT;
				next_doe = dbusy && downer == l2port_pkg::OWN_EXT;
			end
			l2port_pkg::MODE_MULTI: begin
				next_dirty_out = abusy && aowner == l2port_pkg::OWN_CPU1;
				next_twe = abusy && aowner == l2port_pkg::OWN_CPU2;
				next_dcs = abusy && aowner == l2port_pkg::OWN_CPU3;
				next_toe = dbusy && downer == l2port_pkg::OWN_CPU1;
				next_dwe[0] = dbusy && downer == l2port_pkg::OWN_CPU2;
				next_dwe[1] = dbusy && downer == l2port_pkg::OWN_CPU3;
			end
			default: ;
		endcase
	end

	// every pin and answer leaves from a flop
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			{strobe_pin_o, ba0_pin_o, tv_pin_o, adv_pin_o, dcs_pin_o} <= 5'h00;
			{strobe_pin_oe_n_o, ba0_pin_oe_n_o, tv_pin_oe_n_o} <= 3'h7;
			{dirty_out_pin_o, doe_pin_o, toe_pin_o, twe_pin_o} <= 4'h0;
			dwe_pin_o <= 3'h0;
			{cache_busy_o, cache_done_o, cache_hit_o, cache_dirty_o} <= 4'h0;
		end else if (ce_i) begin
			{strobe_pin_o, ba0_pin_o, tv_pin_o} <= {next_strobe, next_ba0, next_tv};
			{strobe_pin_oe_n_o, ba0_pin_oe_n_o} <= {next_strobe_oe_n, next_ba0_oe_n};
			tv_pin_oe_n_o <= next_tv_oe_n;
			{adv_pin_o, dcs_pin_o, dirty_out_pin_o} <= {next_adv, next_dcs, next_dirty_out};
			{doe_pin_o, toe_pin_o, twe_pin_o} <= {next_doe, next_toe, next_twe};
			dwe_pin_o <= next_dwe;
			cache_busy_o <= c_state != l2port_pkg::C_IDLE;
			{cache_done_o, cache_hit_o, cache_dirty_o} <= {done, last_hit, last_dirty};
		end
	end

	assign {s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_bresp_o} =
		{awready, wready, bvalid, bresp};
	assign {s_axi_arready_o, s_axi_rvalid_o, s_axi_rdata_o, s_axi_rresp_o} =
		{arready, rvalid, rdata, rresp};

	// --------------------------------------------------------------------
	// assertions
	// --------------------------------------------------------------------
	default clocking cb @(posedge clock_i iff ce_i); endclocking
	default disable iff (rst_i);

	sequence s_accept;
		c_state == l2port_pkg::C_IDLE && in_int && cache_start_i;
	endsequence
	sequence s_one_pulse;
		##2 strobe_pin_o ##1 !strobe_pin_o;
	endsequence

	a_ads_pulse: assert property (s_accept and cfg_burst |-> s_one_pulse)
		else $error("address strobe not pulsed once");
	a_addr_latch_en_pulse: assert property (s_accept and !cfg_burst |-> s_one_pulse)
		else $error("latch enable not pulsed once");
	a_burst_count: assert property (in_int && !cfg_burst |=> {adv_pin_o, ba0_pin_o} == $past(bcnt))
		else $error("burst counter bits wrong");
	a_advance_beats: assert property (in_int && cfg_burst && w_burst &&
		c_state == l2port_pkg::C_DATA && beats == l2port_pkg::BURST_LAST |=>
		!adv_pin_o ##1 adv_pin_o [*3] ##1 !adv_pin_o)
		else $error("advance pattern wrong");
	a_data_select: assert property (in_int && c_state == l2port_pkg::C_DATA |=>
		dcs_pin_o && doe_pin_o == !$past(w_write))
		else $error("data select or oe wrong");
	a_doe_read: assert property (in_int && doe_pin_o |->
		$past(c_state) == l2port_pkg::C_DATA && dwe_pin_o == 3'h0)
		else $error("data oe outside read");
	a_we_copies: assert property (in_int |-> dwe_pin_o == 3'h0 || dwe_pin_o == 3'h7)
		else $error("write enables differ");
	a_lookup_sample: assert property (in_int && c_state == l2port_pkg::C_LOOKUP &&
		lk_cnt == l2port_pkg::LOOKUP_LAST |=> last_hit == $past(line_hit) &&
		last_dirty == $past(line_dirty))
		else $error("hit or dirty not taken");
	a_tag_oe: assert property (in_int && toe_pin_o |-> $past(c_state) == l2port_pkg::C_LOOKUP)
		else $error("tag oe outside lookup");
	a_tag_update: assert property (in_int && c_state == l2port_pkg::C_TAG |=> twe_pin_o &&
		!tv_pin_oe_n_o && tv_pin_o == cfg[l2port_pkg::CFG_TV_POL] &&
		dirty_out_pin_o == ($past(w_write) ~^ cfg[l2port_pkg::CFG_DOUT_POL]))
		else $error("tag update pins wrong");
	a_ext_grant: assert property (in_ext && !abusy && !dbusy && req[0] |=> abusy ##1 adv_pin_o)
		else $error("external address grant missing");
	a_ext_data: assert property (in_ext && dbusy |=> doe_pin_o)
		else $error("external data grant missing");
	a_cpu_grants: assert property (in_mp |-> $onehot0({dcs_pin_o, twe_pin_o, dirty_out_pin_o}) &&
		$onehot0({dwe_pin_o[1:0], toe_pin_o}) && !(abusy && dbusy))
		else $error("more than one grant");
	a_mode_locked: assert property (cfg[l2port_pkg::CFG_LOCK] |=> $stable(cfg))
		else $error("locked config changed");
endmodule

// ### verification/l2_bus_agent.sv
/*
 bus agent model: acknowledges each new address and data grant.
 assumes one clock shared with the port; one or four beats per tenure.
*/
`timescale 1ns/1ps
module l2_bus_agent (
	// clock and enable
	input wire logic clock_i,
	input wire logic en_i,
	// grants seen on the reused pins
	input wire logic agnt_i,
	input wire logic dgnt_i,
	// burst qualifier of the current tenure
	input wire logic burst_i,
	// acknowledges back to the port
	output logic addr_ack_o = 1'b0,
	output logic transfer_ack_o = 1'b0
);
	logic agnt_q = 1'b0;
	logic dgnt_q = 1'b0;
	logic [1:0] left = 2'h0;
	// one-cycle acks with a gap between beats; held longer they would count twice
	always_ff @(posedge clock_i) begin
		agnt_q <= agnt_i;
		dgnt_q <= dgnt_i;
		addr_ack_o <= en_i && agnt_i && !agnt_q;
		if (en_i && dgnt_i && !dgnt_q) begin
			transfer_ack_o <= 1'b1;
			left <= burst_i ? 2'h3 : 2'h0;
		end else if (left != 2'h0 && !transfer_ack_o) begin
			transfer_ack_o <= 1'b1;
			left <= left - 2'h1;
		end else begin
			transfer_ack_o <= 1'b0;
		end
	end
endmodule

// ### verification/l2_cache_and_multiprocessor_port_tb_top.sv
/*
 testbench of the secondary-cache port: register bus, sequencer, arbiter.
 assumes the port and the bus agent model are compiled first.
*/
`timescale 1ns/1ps
module l2_cache_and_multiprocessor_port_tb_top;
	logic clock_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, hit_i = 1'b0, arb_en = 1'b0;
	logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
	logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0, xfer_burst_i = 1'b0;
	logic cache_start_i = 1'b0, cache_write_i = 1'b0, cache_burst_i = 1'b0;
	logic [1:0] cache_word_i = 2'h2;
	logic [3:0] s_axi_wstrb_i = 4'hF, rq = 4'h0, ag, dg;
	logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
	logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, d;
	logic [1:0] s_axi_bresp_o, s_axi_rresp_o, r;
	logic [2:0] dwe_pin_o;
	logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
	logic cache_busy_o, cache_done_o, cache_hit_o, cache_dirty_o, addr_ack_i, transfer_ack_i;
	logic strobe_pin_o, strobe_pin_oe_n_o, ba0_pin_o, ba0_pin_oe_n_o, tv_pin_o, tv_pin_oe_n_o;
	logic strobe_pin_i, ba0_pin_i, tv_pin_i, dirty_pin_i, adv_pin_o, dcs_pin_o;
	logic dirty_out_pin_o, doe_pin_o, toe_pin_o, twe_pin_o;
	int n_fail = 0;
	int compares = 0;
	// --------------------------------------------------------------------
	// wiring: released pins carry the requests
	// --------------------------------------------------------------------
	assign strobe_pin_i = strobe_pin_oe_n_o ? rq[0] : strobe_pin_o;
	assign dirty_pin_i = rq[1];
	assign tv_pin_i = tv_pin_oe_n_o ? rq[2] : tv_pin_o;
	assign ba0_pin_i = ba0_pin_oe_n_o ? rq[3] : ba0_pin_o;
	assign ag = {dcs_pin_o, twe_pin_o, dirty_out_pin_o, adv_pin_o};
	assign dg = {dwe_pin_o[1:0], toe_pin_o, doe_pin_o};
	l2_cache_and_multiprocessor_port u_dut (.*);
	l2_bus_agent u_agent (.clock_i(clock_i), .en_i(arb_en), .agnt_i(|ag), .dgnt_i(|dg),
		.burst_i(xfer_burst_i),
		.addr_ack_o(addr_ack_i), .transfer_ack_o(transfer_ack_i));
	initial begin
		forever #2 clock_i = ~clock_i;
	end
	// --------------------------------------------------------------------
	// tasks
	// --------------------------------------------------------------------
	task automatic chk(input logic [35:0] g, input logic [35:0] e);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic complete_run;
		$display("mismatches=%0d compares=%0d", n_fail, compares);
		if (n_fail == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// write holds each channel until its own ready, bready until bvalid
	task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		logic pend;
		pend = 1'b1;
		rs = 2'h2;
		@(posedge clock_i);
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= v;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		s_axi_bready_i <= 1'b1;
		while (pend) begin
			@(posedge clock_i);
			if (s_axi_awvalid_i && s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
			if (s_axi_wvalid_i && s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
			if (s_axi_bvalid_o) begin
				rs = s_axi_bresp_o;
				s_axi_bready_i <= 1'b0;
				pend = 1'b0;
			end
		end
	endtask
	task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		logic pend;
		pend = 1'b1;
		rs = 2'h2;
		v = 32'hFFFFFFFF;
		@(posedge clock_i);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i <= 1'b1;
		while (pend) begin
			@(posedge clock_i);
			if (s_axi_arvalid_i && s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
			if (s_axi_rvalid_o) begin
				v = s_axi_rdata_o;
				rs = s_axi_rresp_o;
				s_axi_rready_i <= 1'b0;
				pend = 1'b0;
			end
		end
	endtask
	// one cache access; checks latency and which pins were ever active
	task automatic acc(input logic w, input logic b, input int lat, input logic [11:0] es,
		input logic ed);
		logic [11:0] seen;
		int n;
		seen = 12'h000;
		@(posedge clock_i);
		cache_start_i <= 1'b1;
		cache_write_i <= w;
		cache_burst_i <= b;
		@(posedge clock_i);
		cache_start_i <= 1'b0;
		for (n = 1; n < 40; n++) begin
			@(posedge clock_i);
			seen |= {toe_pin_o, !tv_pin_oe_n_o, cache_busy_o, ba0_pin_o,
				dwe_pin_o != 3'h0 && dwe_pin_o != 3'h7, strobe_pin_o, adv_pin_o,
				dcs_pin_o, doe_pin_o, dwe_pin_o == 3'h7, twe_pin_o, dirty_out_pin_o};
			if (cache_done_o) break;
		end
		chk(n - 1, lat);
		chk(seen, es);
		chk(cache_hit_o, 1'b1);
		chk(cache_dirty_o, ed);
	endtask
	// one request on lane k; only that lane may be granted either bus
	// a four-beat tenure keeps the data grant well past eight cycles, one beat does not
	task automatic arb(input int k, input logic bst);
		logic [3:0] sa, sd;
		int n, nd;
		sa = 4'h0;
		sd = 4'h0;
		nd = 0;
		@(posedge clock_i);
		rq <= 4'h1 << k;
		xfer_burst_i <= bst;
		for (n = 0; n < 12 && !ag[k]; n++) @(posedge clock_i);
		chk(n < 8, 1'b1);
		rq <= 4'h0;
		for (int i = 0; i < 30; i++) begin
			@(posedge clock_i);
			sa |= ag;
			sd |= dg;
			nd += (dg != 4'h0);
		end
		chk({sa, sd, ag, dg}, {4'h1 << k, 4'h1 << k, 8'h00});
		chk(nd > 8, bst);
	endtask
	// --------------------------------------------------------------------
	// main sequence and watchdog
	// --------------------------------------------------------------------
	initial begin
		repeat (10) @(posedge clock_i);
		rst_i <= 1'b0;
		hit_i <= 1'b1;
		axr(8'h00, d, r);
		chk({r, d}, {2'h0, 32'h078});
		axr(8'h08, d, r);
		chk({r, d}, {2'h3, 32'h0});
		axw(8'h08, 32'h5, r);
		chk(r, 2'h3);
		axw(8'h00, 32'h07B, r);
		axr(8'h00, d, r);
		chk({r, d}, {2'h0, 32'h078});
		acc(1'b0, 1'b0, 5, 12'hB78, 1'b0);
		axw(8'h00, 32'h07C, r);
		acc(1'b0, 1'b1, 8, 12'hA78, 1'b0);
		axw(8'h00, 32'h064, r);
		hit_i <= 1'b0;
		acc(1'b1, 1'b0, 6, 12'hE57, 1'b1);
		axr(8'h04, d, r);
		chk({r, d}, {2'h0, 32'h006});
		axw(8'h00, 32'h07A, r);
		arb_en <= 1'b1;
		for (int k = 1; k < 4; k++) arb(k, k == 2);
		axw(8'h00, 32'h079, r);
		arb(0, 1'b0);
		axw(8'h00, 32'h178, r);
		axw(8'h00, 32'h07A, r);
		chk(r, 2'h0);
		axr(8'h00, d, r);
		chk(d, 32'h178);
		complete_run();
	end
	initial begin
		#20000;
		n_fail++;
		complete_run();
	end
endmodule
